// File: rtl/flash_abort_host.sv
// host controller that drives the parallel flash pins and recovers from a buffer abort
`timescale 1ns/1ns
module flash_abort_host #(
	parameter int AW            = 26,
	parameter int WE_CYC        = 3,
	parameter int RD_CYC        = 5,
	parameter int GAP_CYC       = 2,
	parameter int LINE_BITS     = 4,
	parameter int LINE_LSB      = 9,
	parameter int SETTLE_CYC    = flash_host_pkg::RESUME_TYP_CYC,
	parameter int ERASE_MAX_CYC = flash_host_pkg::ERASE_MAX_CYC
)(
	// clock and reset
	input  wire logic          clk,
	input  wire logic          resetn,
	// software register port
	input  wire logic [7:0]    reg_addr,
	input  wire logic [31:0]   reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic      [31:0]   reg_rdata,
	// flash pins
	output logic      [AW-1:0] f_addr,
	input  wire logic [15:0]   f_dq_in,
	output logic      [15:0]   f_dq_out,
	output logic               f_dq_oe,
	output logic               f_ce_n,
	output logic               f_oe_n,
	output logic               f_we_n,
	input  wire logic          ready_busy_n_output
);

	localparam int LINES = 1 << LINE_BITS;
	localparam int SW    = $clog2(SETTLE_CYC + 1);
	localparam int WW    = $clog2(ERASE_MAX_CYC + 1);
	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_GAP  = 5'b00010,
		S_WR   = 5'b00100,
		S_RD   = 5'b01000,
		S_WAIT = 5'b10000
	} state_t;
	state_t                     state_r;
	flash_host_pkg::seq_t       seq_r;
	flash_host_pkg::seq_t       go_seq;
	flash_host_pkg::step_t      st;
	logic [1:0]                 step_r;
	logic [7:0]                 cnt_r;
	logic                       rb_s1_r, rb_s2_r;
	logic [15:0]                dq_s1_r, dq_s2_r;
	logic [AW-1:0]              addr_r;
	logic [15:0]                data_r;
	logic [15:0]                poll0_r, poll1_r;
	logic [7:0]                 sr_r;
	logic                       sel_abr_r, abort_r, cleared_r, refused_r, timeout_r, dq7_ok_r, resumed_r;
	logic [SW-1:0]              res_cnt_r;
	logic [WW-1:0]              wd_cnt_r;
	logic [8:0]                 line_cnt_r [LINES];
	logic [LINE_BITS-1:0]       line_idx;
	logic                       cmd_wr, go, go_ok, start_ok, step_end, poll_end, poll_abort, wd_hit;

	assign st       = flash_host_pkg::step_lookup(seq_r, step_r);
	assign line_idx = addr_r[LINE_LSB +: LINE_BITS];
	assign cmd_wr   = reg_wr && reg_addr == flash_host_pkg::REG_CMD;
	assign step_end = (state_r == S_WR && cnt_r == 8'(WE_CYC - 1)) || (state_r == S_RD && cnt_r == 8'(RD_CYC - 1));
	assign poll_end = state_r == S_RD && step_end && st.last && seq_r == flash_host_pkg::SEQ_POLL;
	assign wd_hit   = wd_cnt_r == WW'(ERASE_MAX_CYC);
	// pick one order per command write; recovery has priority over everything else
	always_comb begin
		go     = cmd_wr && (reg_wdata[flash_host_pkg::CMD_RECOVER] || reg_wdata[flash_host_pkg::CMD_SR_READ]
			|| reg_wdata[flash_host_pkg::CMD_PROGRAM] || reg_wdata[flash_host_pkg::CMD_SUSPEND]
			|| reg_wdata[flash_host_pkg::CMD_RESUME]);
		go_seq = flash_host_pkg::SEQ_RES;
		go_ok  = 1'b1;
		if (reg_wdata[flash_host_pkg::CMD_RECOVER]) begin
			go_seq = flash_host_pkg::SEQ_POLL;
		end else if (reg_wdata[flash_host_pkg::CMD_SR_READ]) begin
			go_seq = flash_host_pkg::SEQ_SRRD;
		end else if (reg_wdata[flash_host_pkg::CMD_PROGRAM]) begin
			go_seq = flash_host_pkg::SEQ_PROG;
			go_ok  = line_cnt_r[line_idx] < 9'(flash_host_pkg::LINE_OP_LIMIT);
		end else if (reg_wdata[flash_host_pkg::CMD_SUSPEND]) begin
			go_seq = flash_host_pkg::SEQ_SUSP;
			go_ok  = !resumed_r || res_cnt_r >= SW'(flash_host_pkg::RESUME_MIN_CYC);
		end
		start_ok = go && go_ok && state_r == S_IDLE;
	end

	// toggle bit differs between reads; timeout clear; abort set; bits 4 and 0 unused
	assign poll_abort = poll_end && (poll0_r[flash_host_pkg::POLL_TOGGLE] != dq_s2_r[flash_host_pkg::POLL_TOGGLE])
		&& dq_s2_r[flash_host_pkg::POLL_ABORT] && !dq_s2_r[flash_host_pkg::POLL_TIMEOUT];
	// pin inputs pass two flops before anything looks at them
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rb_s1_r <= 1'b1;
			rb_s2_r <= 1'b1;
			dq_s1_r <= 16'h0000;
			dq_s2_r <= 16'h0000;
		end else begin
			rb_s1_r <= ready_busy_n_output;
			rb_s2_r <= rb_s1_r;
			dq_s1_r <= f_dq_in;
			dq_s2_r <= dq_s1_r;
		end
	end

	// bus-cycle sequencer; read strobe is held long enough to cover the synchroniser
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= S_IDLE;
			seq_r   <= flash_host_pkg::SEQ_POLL;
			step_r  <= 2'h0;
			cnt_r   <= 8'h00;
		end else begin
			cnt_r <= cnt_r + 8'h01;
			case (state_r)
				S_IDLE: begin
					if (start_ok) begin
						seq_r   <= go_seq;
						step_r  <= 2'h0;
						cnt_r   <= 8'h00;
						state_r <= S_GAP;
					end
				end
				S_GAP: begin
					if (cnt_r == 8'(GAP_CYC - 1)) begin
						cnt_r   <= 8'h00;
						state_r <= st.rd ? S_RD : S_WR;
					end
				end
				S_WR, S_RD: begin
					if (step_end) begin
						cnt_r <= 8'h00;
						if (poll_abort) begin
							// abort seen, issue the chosen clear at once
							seq_r   <= sel_abr_r ? flash_host_pkg::SEQ_ABR : flash_host_pkg::SEQ_CLR;
							step_r  <= 2'h0;
							state_r <= S_GAP;
						end else if (!st.last) begin
							step_r  <= step_r + 2'h1;
							state_r <= S_GAP;
						end else if (seq_r == flash_host_pkg::SEQ_CLR || seq_r == flash_host_pkg::SEQ_ABR) begin
							state_r <= S_WAIT;
						end else begin
							state_r <= S_IDLE;
						end
					end
				end
				S_WAIT: begin
					if (rb_s2_r || wd_hit) begin
						state_r <= S_IDLE;
					end
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// address and data launched from flops one gap ahead of each strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			f_addr   <= '0;
			f_dq_out <= 16'h0000;
		end else if (state_r == S_GAP) begin
			f_addr   <= st.user ? addr_r : AW'(st.addr);
			f_dq_out <= st.user ? data_r : st.data;
		end
	end

	assign f_ce_n  = !(state_r == S_WR || state_r == S_RD);
	assign f_we_n  = !(state_r == S_WR);
	assign f_oe_n  = !(state_r == S_RD);
	assign f_dq_oe = state_r == S_WR;
	// captured polling words and status byte
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			poll0_r <= 16'h0000;
			poll1_r <= 16'h0000;
			sr_r    <= 8'h00;
		end else if (state_r == S_RD && step_end) begin
			if (seq_r == flash_host_pkg::SEQ_SRRD) begin
				// status byte read, device falls back to abort busy
				sr_r <= dq_s2_r[7:0];
			end else if (step_r == 2'h0) begin
				poll0_r <= dq_s2_r;
			end else begin
				poll1_r <= dq_s2_r;
			end
		end
	end

	// software settings and sticky flags; a hardware set wins over a clearing write
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			addr_r    <= '0;
			data_r    <= 16'h0000;
			sel_abr_r <= 1'b0;
			abort_r   <= 1'b0;
			cleared_r <= 1'b0;
			refused_r <= 1'b0;
			timeout_r <= 1'b0;
			dq7_ok_r  <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == flash_host_pkg::REG_ADDR) begin
				addr_r <= reg_wdata[AW-1:0];
			end
			if (reg_wr && reg_addr == flash_host_pkg::REG_DATA) begin
				data_r <= reg_wdata[15:0];
			end
			if (cmd_wr) begin
				sel_abr_r <= reg_wdata[flash_host_pkg::CMD_ABORT_SEL];
			end
			if (reg_wr && reg_addr == flash_host_pkg::REG_STATUS) begin
				abort_r   <= abort_r & ~reg_wdata[flash_host_pkg::ST_ABORT];
				refused_r <= refused_r & ~reg_wdata[flash_host_pkg::ST_REFUSED];
				timeout_r <= timeout_r & ~reg_wdata[flash_host_pkg::ST_TIMEOUT];
			end
			if (start_ok) begin
				cleared_r <= 1'b0;
			end
			if (poll_abort) begin
				abort_r  <= 1'b1;
				// data bit 7 should be the complement of the last loaded word
				dq7_ok_r <= dq_s2_r[flash_host_pkg::POLL_DATA_COMP] == !data_r[7];
			end
			if (go && !start_ok) begin
				refused_r <= 1'b1;
			end
			if (state_r == S_WAIT && wd_hit) begin
				timeout_r <= 1'b1;
			end
			if (state_r == S_WAIT && rb_s2_r) begin
				cleared_r <= 1'b1;
			end
		end
	end

	// time since last resume; settled flag tells software the typical span has passed
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			resumed_r <= 1'b0;
			res_cnt_r <= '0;
		end else if (start_ok && go_seq == flash_host_pkg::SEQ_RES) begin
			resumed_r <= 1'b1;
			res_cnt_r <= '0;
		end else if (res_cnt_r != SW'(SETTLE_CYC)) begin
			res_cnt_r <= res_cnt_r + SW'(1);
		end
	end

	// busy watchdog sized for the longest sector erase
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wd_cnt_r <= '0;
		end else if (rb_s2_r) begin
			wd_cnt_r <= '0;
		end else if (!wd_hit) begin
			wd_cnt_r <= wd_cnt_r + WW'(1);
		end
	end

	// program count per line, cleared when software reports an erase
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < LINES; i++) begin
				line_cnt_r[i] <= 9'h000;
			end
		end else if (cmd_wr && reg_wdata[flash_host_pkg::CMD_ERASED]) begin
			for (int i = 0; i < LINES; i++) begin
				line_cnt_r[i] <= 9'h000;
			end
		end else if (start_ok && go_seq == flash_host_pkg::SEQ_PROG) begin
			line_cnt_r[line_idx] <= line_cnt_r[line_idx] + 9'h001;
		end
	end

	// register read data, one cycle after the strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				flash_host_pkg::REG_ADDR:   reg_rdata <= 32'(addr_r);
				flash_host_pkg::REG_DATA:   reg_rdata <= {16'h0000, data_r};
				flash_host_pkg::REG_STATUS: reg_rdata <= {24'h000000, dq7_ok_r, res_cnt_r == SW'(SETTLE_CYC),
					timeout_r, rb_s2_r, refused_r, cleared_r, abort_r, state_r != S_IDLE};
				// reserved poll bits masked before software sees them
				flash_host_pkg::REG_POLL:   reg_rdata <= {16'h0000, poll1_r & 16'hFFEE};
				flash_host_pkg::REG_OPSTAT: reg_rdata <= {24'h000000, sr_r};
				default:                    reg_rdata <= 32'h0000_0000;
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	suspend_spacing_a: assert property (
		start_ok && go_seq == flash_host_pkg::SEQ_SUSP |-> !resumed_r || res_cnt_r >= SW'(flash_host_pkg::RESUME_MIN_CYC))
		else $error("suspend issued too soon after resume");
	line_limit_a: assert property (
		start_ok && go_seq == flash_host_pkg::SEQ_PROG |-> line_cnt_r[line_idx] < 9'(flash_host_pkg::LINE_OP_LIMIT)
			##1 refused_r == $past(refused_r))
		else $error("program beyond line limit");
	clear_follows_a: assert property (
		poll_abort |=> state_r == S_GAP && abort_r && (seq_r == flash_host_pkg::SEQ_CLR || seq_r == flash_host_pkg::SEQ_ABR))
		else $error("abort not followed by clear");
	release_idle_a: assert property (
		state_r == S_WAIT && rb_s2_r |=> state_r == S_IDLE && cleared_r)
		else $error("ready release not seen");
	poll_masked_a: assert property (
		reg_rd && reg_addr == flash_host_pkg::REG_POLL |=> reg_rdata[4] == 1'b0 && reg_rdata[0] == 1'b0)
		else $error("reserved poll bits leaked");
endmodule

// File: rtl/flash_host_pkg.sv
// constants, command codes and bus-cycle step table for the flash abort-recovery host
package flash_host_pkg;

	// time figures, the cycle counts derived from them and the per-line program limit
	localparam int unsigned CLK_PERIOD_NS   = 20;
	localparam int unsigned T_RESUME_MIN_NS = 60;
	localparam int unsigned T_RESUME_TYP_US = 100;
	localparam int unsigned T_ERASE_MAX_MS  = 1100;
	localparam int unsigned RESUME_MIN_CYC  = (T_RESUME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RESUME_TYP_CYC  = (T_RESUME_TYP_US * 1000) / CLK_PERIOD_NS;
	localparam longint unsigned ERASE_MAX_CYC_L = (64'(T_ERASE_MAX_MS) * 64'd1000000) / CLK_PERIOD_NS;
	localparam int unsigned ERASE_MAX_CYC   = int'(ERASE_MAX_CYC_L);
	localparam int unsigned LINE_OP_LIMIT   = 256;

	// software register byte offsets
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_DATA   = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_POLL   = 8'h10;
	localparam logic [7:0] REG_OPSTAT = 8'h14;

	// command register bits
	localparam int CMD_RECOVER   = 0;
	localparam int CMD_ABORT_SEL = 1;
	localparam int CMD_SR_READ   = 2;
	localparam int CMD_SUSPEND   = 3;
	localparam int CMD_RESUME    = 4;
	localparam int CMD_PROGRAM   = 5;
	localparam int CMD_ERASED    = 6;

	// status register bits; bits 1, 3 and 5 clear by writing one
	localparam int ST_BUSY      = 0;
	localparam int ST_ABORT     = 1;
	localparam int ST_CLEARED   = 2;
	localparam int ST_REFUSED   = 3;
	localparam int ST_DEV_READY = 4;
	localparam int ST_TIMEOUT   = 5;
	localparam int ST_SETTLED   = 6;
	localparam int ST_DQ7_OK    = 7;
	localparam int ST_W1C_LO    = ST_ABORT;

	// polling bit positions on the device data bus
	localparam int POLL_DATA_COMP  = 7;
	localparam int POLL_TOGGLE     = 6;
	localparam int POLL_TIMEOUT    = 5;
	localparam int POLL_RSV_HI     = 4;
	localparam int POLL_ERASE_ACT  = 3;
	localparam int POLL_ERASE_TOG  = 2;
	localparam int POLL_ABORT      = 1;
	localparam int POLL_RSV_LO     = 0;

	// device command cycles
	localparam logic [11:0] ADDR_UNLOCK1  = 12'h555;
	localparam logic [11:0] ADDR_UNLOCK2  = 12'h2AA;
	localparam logic [15:0] CMD_UNLOCK1   = 16'h00AA;
	localparam logic [15:0] CMD_UNLOCK2   = 16'h0055;
	localparam logic [15:0] CMD_ABORT_RST = 16'h00F0;
	localparam logic [15:0] CMD_SR_RD     = 16'h0070;
	localparam logic [15:0] CMD_SR_CLR    = 16'h0071;
	localparam logic [15:0] CMD_PROG      = 16'h00A0;
	localparam logic [15:0] CMD_SUSP      = 16'h00B0;
	localparam logic [15:0] CMD_RES       = 16'h0030;

	typedef enum logic [2:0] {
		SEQ_POLL, SEQ_CLR, SEQ_ABR, SEQ_SRRD, SEQ_PROG, SEQ_SUSP, SEQ_RES
	} seq_t;

	typedef struct packed {
		logic        rd;
		logic        last;
		logic        user;
		logic [11:0] addr;
		logic [15:0] data;
	} step_t;

	// one bus cycle of a command sequence
	function automatic step_t step_lookup(input seq_t s, input logic [1:0] n);
		step_t st;
		st = '{rd: 1'b0, last: 1'b1, user: 1'b0, addr: ADDR_UNLOCK1, data: CMD_SR_CLR};
		if ((s == SEQ_ABR || s == SEQ_PROG) && n != 2'h2 && n != 2'h3) begin
			st.last = 1'b0;
			st.addr = n[0] ? ADDR_UNLOCK2 : ADDR_UNLOCK1;
			st.data = n[0] ? CMD_UNLOCK2 : CMD_UNLOCK1;
		end else begin
			case (s)
				SEQ_POLL: begin
					st.rd   = 1'b1;
					st.user = 1'b1;
					st.last = n[0];
				end
				SEQ_ABR:  st.data = CMD_ABORT_RST;
				SEQ_SRRD: begin
					st.rd   = n[0];
					st.last = n[0];
					st.data = CMD_SR_RD;
				end
				SEQ_PROG: begin
					st.last = (n == 2'h3);
					st.user = (n == 2'h3);
					st.data = CMD_PROG;
				end
				SEQ_SUSP: st.data = CMD_SUSP;
				SEQ_RES:  st.data = CMD_RES;
				default:  st.data = CMD_SR_CLR;
			endcase
		end
		return st;
	endfunction

endpackage

// File: test/flash_device_model.sv
// behavioural flash device on the parallel pins, covering the buffer-abort error state
`timescale 1ns/1ns
module flash_device_model #(
	parameter int AW = 26
)(
	// pins from the host
	input  wire logic [AW-1:0] f_addr,
	input  wire logic [15:0]   f_dq_out,
	input  wire logic          f_ce_n,
	input  wire logic          f_oe_n,
	input  wire logic          f_we_n,
	// pins to the host
	output logic      [15:0]   dev_dq,
	output logic               ready_busy_n_output,
	// scenario controls from the bench
	input  wire logic          go_abort,
	input  wire logic          hang,
	input  wire logic [15:0]   last_word
);
	logic       ab  = 1'b0;
	logic       tog = 1'b0;
	logic       srm = 1'b0;
	logic [1:0] ul  = 2'h0;
	logic [7:0] sr;

	assign sr = ab ? 8'h99 : 8'h80;

	initial begin
		dev_dq = 16'hA5A5;
		ready_busy_n_output = 1'b1;
	end

	always @(posedge go_abort) begin
		ab = 1'b1;
		tog = 1'b0;
		ready_busy_n_output = 1'b0;
	end

	// only clear, abort reset and status read act
	// strobe and chip enable switch in one step, so the cycle is taken a step into the strobe
	always @(negedge f_we_n) begin
		#1;
		if (!f_ce_n) begin
			if ((f_addr[11:0] == 12'h555 && f_dq_out[7:0] == 8'h71) || (ul == 2'h2 && f_dq_out[7:0] == 8'hF0)) begin
				ab = 1'b0;
				srm = 1'b0;
				// a stuck device never releases busy, to exercise the watchdog
				if (!hang) ready_busy_n_output <= #100 1'b1;
			end else if (f_addr[11:0] == 12'h555 && f_dq_out[7:0] == 8'h70) begin
				srm = 1'b1;
			end
			ul = (f_addr[11:0] == 12'h555 && f_dq_out[7:0] == 8'hAA) ? 2'h1
				: (ul == 2'h1 && f_addr[11:0] == 12'h2AA && f_dq_out[7:0] == 8'h55) ? 2'h2 : 2'h0;
		end
	end

	always @(negedge f_oe_n) begin
		#1;
		if (!f_ce_n) begin
			if (srm) begin
				dev_dq = {8'h00, sr};
				srm = 1'b0;
			end else if (ab) begin
				dev_dq = {8'h00, ~last_word[7], tog, 6'b011011};
				tog = ~tog;
			end else begin
				dev_dq = 16'h1234;
			end
		end
	end

	// released bus shows the inverse so a stale value cannot pass
	always @(posedge f_oe_n) dev_dq = ~dev_dq;
endmodule

// File: test/tb_flash_abort_host.sv
// self-checking bench for the flash abort-recovery host
`timescale 1ns/1ns
module tb_flash_abort_host;
	typedef struct packed {logic ab; logic sel; logic [15:0] lw; logic [7:0] st; logic [15:0] poll;} row_t;
	// clock, reset and register port
	logic        clk       = 1'b0;
	logic        resetn    = 1'b0;
	logic [7:0]  reg_addr  = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [31:0] reg_rdata;
	// pins and device controls
	logic [25:0] f_addr;
	logic [15:0] f_dq_in, f_dq_out, dev_dq;
	logic        f_dq_oe, f_ce_n, f_oe_n, f_we_n, rdy;
	logic        go_abort  = 1'b0;
	logic        hang      = 1'b0;
	logic [15:0] lw_r      = 16'h0;
	int          err_total = 0;
	int          total_checks = 0;
	int          cyc       = 0;
	logic [31:0] q;
	row_t        rows [4]  = '{'{1'b0, 1'b0, 16'h0000, 8'h10, 16'h1224}, '{1'b1, 1'b0, 16'h0080, 8'h96, 16'h004A},
	                          '{1'b1, 1'b1, 16'h0000, 8'h96, 16'h00CA}, '{1'b1, 1'b1, 16'h0080, 8'h96, 16'h004A}};

	// the wire level: host drives only in its write phase
	assign f_dq_in = f_dq_oe ? f_dq_out : dev_dq;

	flash_abort_host #(.SETTLE_CYC(20), .ERASE_MAX_CYC(200)) dut (.clk(clk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.f_addr(f_addr), .f_dq_in(f_dq_in), .f_dq_out(f_dq_out), .f_dq_oe(f_dq_oe), .f_ce_n(f_ce_n),
		.f_oe_n(f_oe_n), .f_we_n(f_we_n), .ready_busy_n_output(rdy));

	flash_device_model dev (.f_addr(f_addr), .f_dq_out(f_dq_out), .f_ce_n(f_ce_n), .f_oe_n(f_oe_n),
		.f_we_n(f_we_n), .dev_dq(dev_dq), .ready_busy_n_output(rdy), .go_abort(go_abort), .hang(hang),
		.last_word(lw_r));

	always #10 clk = ~clk;

	task automatic test_done();
		$display("checks=%0d errors=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// a hang counts as a mismatch and ends the run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// read data stand from the cycle after the strobe until the next read
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic idle();
		for (int i = 0; i < 300; i++) begin
			rd(flash_host_pkg::REG_STATUS, q);
			if (q[0] === 1'b0) break;
		end
	endtask

	task automatic abort_dev(input logic [15:0] w);
		lw_r <= w;
		go_abort <= 1'b1;
		@(posedge clk);
		go_abort <= 1'b0;
	endtask

	initial begin
		repeat (2) @(posedge clk);
		chk(reg_rdata, 32'h0);
		resetn <= 1'b1;
		rd(8'h20, q);
		chk(q, 32'h0);
		rd(flash_host_pkg::REG_STATUS, q);
		chk(q & 32'hBF, 32'h10);
		// ordinary recoveries: both clearing commands, both polarities of the last word
		foreach (rows[i]) begin
			wr(flash_host_pkg::REG_STATUS, 32'h2A);
			if (rows[i].ab) abort_dev(rows[i].lw);
			wr(flash_host_pkg::REG_DATA, {16'h0, rows[i].lw});
			wr(flash_host_pkg::REG_ADDR, 32'h100);
			wr(flash_host_pkg::REG_CMD, {30'h0, rows[i].sel, 1'b1});
			idle();
			rd(flash_host_pkg::REG_STATUS, q);
			chk(q & {24'h0, rows[i].ab, 7'h3F}, {24'h0, rows[i].st & {rows[i].ab, 7'h3F}});
			rd(flash_host_pkg::REG_POLL, q);
			chk(q, {16'h0, rows[i].poll});
		end
		// a program the device ignores and a status read leave the abort standing
		wr(flash_host_pkg::REG_STATUS, 32'h2A);
		abort_dev(16'h0080);
		wr(flash_host_pkg::REG_DATA, 32'h0080);
		wr(flash_host_pkg::REG_CMD, 32'h20);
		idle();
		wr(flash_host_pkg::REG_CMD, 32'h4);
		idle();
		rd(flash_host_pkg::REG_OPSTAT, q);
		chk(q & 32'hFE, 32'h98);
		wr(flash_host_pkg::REG_CMD, 32'h3);
		idle();
		rd(flash_host_pkg::REG_STATUS, q);
		chk(q & 32'hBF, 32'h96);
		wr(flash_host_pkg::REG_CMD, 32'h4);
		idle();
		rd(flash_host_pkg::REG_OPSTAT, q);
		chk(q & 32'hFE, 32'h80);
		rd(flash_host_pkg::REG_ADDR, q);
		chk(q, 32'h100);
		rd(flash_host_pkg::REG_DATA, q);
		chk(q, 32'h80);
		// a suspend while the resume still runs is refused, a later one is taken
		wr(flash_host_pkg::REG_STATUS, 32'h2A);
		wr(flash_host_pkg::REG_CMD, 32'h10);
		wr(flash_host_pkg::REG_CMD, 32'h8);
		rd(flash_host_pkg::REG_STATUS, q);
		chk(q & 32'h49, 32'h09);
		repeat (25) @(posedge clk);
		wr(flash_host_pkg::REG_STATUS, 32'h2A);
		wr(flash_host_pkg::REG_CMD, 32'h8);
		idle();
		rd(flash_host_pkg::REG_STATUS, q);
		chk(q & 32'h4F, 32'h40);
		// the line takes its full count of programs, then refuses until erased
		wr(flash_host_pkg::REG_CMD, 32'h40);
		for (int i = 0; i < flash_host_pkg::LINE_OP_LIMIT; i++) begin
			wr(flash_host_pkg::REG_CMD, 32'h20);
			idle();
		end
		rd(flash_host_pkg::REG_STATUS, q);
		chk({31'h0, q[3]}, 32'h0);
		wr(flash_host_pkg::REG_CMD, 32'h20);
		rd(flash_host_pkg::REG_STATUS, q);
		chk(q & 32'h09, 32'h08);
		wr(flash_host_pkg::REG_STATUS, 32'h2A);
		wr(flash_host_pkg::REG_CMD, 32'h40);
		wr(flash_host_pkg::REG_CMD, 32'h20);
		idle();
		rd(flash_host_pkg::REG_STATUS, q);
		chk(q & 32'h09, 32'h00);
		// a device that stays busy after clearing trips the watchdog
		wr(flash_host_pkg::REG_STATUS, 32'h2A);
		hang <= 1'b1;
		abort_dev(16'h0080);
		wr(flash_host_pkg::REG_CMD, 32'h1);
		idle();
		rd(flash_host_pkg::REG_STATUS, q);
		chk({31'h0, q[5]}, 32'h1);
		// a reset in mid-run drops the busy, abort, cleared, refused and timeout flags
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		rd(flash_host_pkg::REG_STATUS, q);
		chk(q & 32'h2F, 32'h0);
		test_done();
	end
endmodule
